// ==== rtl/acrb_defines.vh ====
// Constants for the converter configuration register bank
`ifndef ACRB_DEFINES_VH
`define ACRB_DEFINES_VH
`define ACRB_ADDR_SETUP 8'h00
`define ACRB_ADDR_PARTID 8'h01
`define ACRB_ADDR_GRADE 8'h02
`define ACRB_ADDR_MODES 8'h08
`define ACRB_ADDR_COMMIT 8'hff
`define ACRB_ADDR_FUNC_LO 8'h08
`define ACRB_ADDR_FUNC_HI 8'h2a
`define ACRB_SETUP_RESET 8'h18
`define ACRB_MODES_RESET 8'h00
`define ACRB_COMMIT_RESET 8'h00
`define ACRB_BIT_LSB_HI 6
`define ACRB_BIT_LSB_LO 1
`define ACRB_BIT_SRST_HI 5
`define ACRB_BIT_SRST_LO 2
`define ACRB_BIT_PIN_SEL 5
`define ACRB_BIT_COMMIT 0
`define ACRB_PD_NORMAL 3'b000
`define ACRB_PD_FULL 3'b001
`define ACRB_PD_STANDBY 3'b010
`define ACRB_PD_NORMAL2 3'b011
`define ACRB_SRST_CYCLES 4'h4
`define ACRB_OB_NEG 8'h00
`define ACRB_OB_POS 8'hff
`define ACRB_OB_MID 8'h80
`endif

// ==== rtl/acrb_sync.v ====
// Two-flop synchroniser for the serial port pins
module acrb_sync (
    input wire ref_clk,
    input wire reset_n,
    input wire din,
    output reg dout
);
    reg stage1;
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // acrb_sync

// ==== rtl/acrb_bank.v ====
// Converter configuration register bank behind a three-wire serial port
//
// Function
// R1 - Offset binary codes 00/80/ff; overrange only beyond full scale by half LSB.
// R2 - Twos complement codes 80/00/7f, saturating beyond range.
// R3 - Decode groups: chip config 00-02, commit at ff, functions 08-2a.
// R4 - Host writes undefined or reserved locations only with defaults or zero.
// R5 - Reset loads critical defaults; registers without default keep their value.
// R6 - Setup register resets 18; bit order bits 6,1; soft reset 5,2; 4,3 one.
// R7 - Host writes setup upper nibble as mirror of lower nibble.
// R8 - Read-only eight bit part identifier ignores writes.
// R9 - Read-only speed grade; low three bits undefined, upper three zero.
// R10 - Commit bit copies staged settings into active registers; resets to 00.
// R11 - Power-down field: 000/011 normal, 001 full, 010 standby; resets 000.
// R12 - Power-down pin overrides field; bit 5 picks full (0) or standby (1).
// R13 - Shift most significant bit first until bit order changed.
// R14 - Transaction is 16-bit instruction then data bytes counted by two length bits.
// R15 - Soft reset bits clear themselves after the internal reset completes.
module acrb_bank #(
    parameter [7:0] PART_ID = 8'h5a, // Arbitrary identifier value
    parameter [1:0] SPEED_GRADE = 2'b01
) (
    input wire ref_clk,
    input wire reset_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdio_in,
    output reg spi_sdio_out,
    output reg spi_sdio_oe,
    input wire powerdown_pin,
    input wire [7:0] raw_sample,
    input wire over_pos,
    input wire over_neg,
    input wire twos_comp_sel,
    output reg [7:0] sample_output_bus,
    output reg overrange,
    output reg [1:0] power_state
);
`include "acrb_defines.vh"
    // --------------------------------
    // Pin synchronisers
    // --------------------------------
    wire sclk_s;
    wire cs_act_s;
    wire sdio_s;
    acrb_sync u_sclk (.ref_clk(ref_clk), .reset_n(reset_n), .din(spi_sclk), .dout(sclk_s));
    // Select is synchronised inverted so that the cleared stages read as a deselected port
    acrb_sync u_cs (.ref_clk(ref_clk), .reset_n(reset_n), .din(~spi_cs_n), .dout(cs_act_s));
    wire cs_n_s = ~cs_act_s;
    acrb_sync u_sdio (.ref_clk(ref_clk), .reset_n(reset_n), .din(spi_sdio_in), .dout(sdio_s));
    reg sclk_d;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;

    // --------------------------------
    // Registers
    // --------------------------------
    reg [7:0] serial_port_setup;
    reg [7:0] power_mode_control;
    reg [7:0] power_mode_staged;
    reg [7:0] shadow_commit;
    reg [3:0] srst_cnt;
    reg [2:0] grade_low;
    wire lsb_first = serial_port_setup[`ACRB_BIT_LSB_HI] | serial_port_setup[`ACRB_BIT_LSB_LO];

    function [7:0] acrb_read;
        input [7:0] addr;
        begin
            case (addr)
                `ACRB_ADDR_SETUP: acrb_read = serial_port_setup;
                `ACRB_ADDR_PARTID: acrb_read = PART_ID; // R8
                `ACRB_ADDR_GRADE: acrb_read = {3'b000, SPEED_GRADE, grade_low}; // R9
                `ACRB_ADDR_MODES: acrb_read = power_mode_staged;
                `ACRB_ADDR_COMMIT: acrb_read = shadow_commit;
                default: acrb_read = 8'h00;
            endcase
        end
    endfunction

    // --------------------------------
    // Serial frame engine
    // --------------------------------
    localparam ST_INSTR = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_DONE = 2'd2;
    reg [1:0] state;
    reg [15:0] instr;
    reg [4:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] addr;
    reg [2:0] bytes_left;
    reg rd_mode;
    reg [7:0] rd_byte;
    reg [2:0] rd_idx;
    wire [15:0] instr_n = lsb_first ? {sdio_s, instr[15:1]} : {instr[14:0], sdio_s}; // R13
    wire [7:0] shreg_n = lsb_first ? {sdio_s, shreg[7:1]} : {shreg[6:0], sdio_s}; // R13
    // Instruction word rw, w1, w0, 13-bit address; the shift direction already undoes the bit order
    wire [15:0] instr_v = instr_n;
    wire [7:0] wr_data = shreg_n;
    wire in_func = (addr >= `ACRB_ADDR_FUNC_LO) && (addr <= `ACRB_ADDR_FUNC_HI); // R3
    wire [2:0] pd_field = power_mode_control[2:0];

    always @(posedge ref_clk) begin
        sclk_d <= sclk_s;
        if (!reset_n) begin
            sclk_d <= 1'b0;
            state <= ST_INSTR;
            instr <= 16'h0000;
            bit_cnt <= 5'd0;
            shreg <= 8'h00;
            addr <= 8'h00;
            bytes_left <= 3'd0;
            rd_mode <= 1'b0;
            rd_byte <= 8'h00;
            rd_idx <= 3'd0;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
            serial_port_setup <= `ACRB_SETUP_RESET; // R5 R6
            power_mode_control <= `ACRB_MODES_RESET; // R5 R11
            power_mode_staged <= `ACRB_MODES_RESET;
            shadow_commit <= `ACRB_COMMIT_RESET; // R10
            srst_cnt <= 4'h0;
        end else begin
            // Soft reset counts down then clears its bits and restores defaults
            if (srst_cnt != 4'h0) begin
                srst_cnt <= srst_cnt - 4'h1;
                if (srst_cnt == 4'h1) begin
                    serial_port_setup <= `ACRB_SETUP_RESET; // R15
                    power_mode_control <= `ACRB_MODES_RESET;
                    power_mode_staged <= `ACRB_MODES_RESET;
                end
            end
            if (shadow_commit[`ACRB_BIT_COMMIT]) begin
                power_mode_control <= power_mode_staged; // R10
                shadow_commit <= 8'h00;
            end
            if (cs_n_s) begin
                state <= ST_INSTR;
                bit_cnt <= 5'd0;
                spi_sdio_oe <= 1'b0;
            end else if (sclk_rise) begin
                case (state)
                    ST_INSTR: begin
                        instr <= instr_n;
                        bit_cnt <= bit_cnt + 5'd1;
                        if (bit_cnt == 5'd15) begin
                            state <= ST_DATA; // R14
                            bit_cnt <= 5'd0;
                            rd_mode <= instr_v[15];
                            bytes_left <= (instr_v[14:13] == 2'b11) ? 3'd7 : {1'b0, instr_v[14:13]};
                            addr <= instr_v[7:0];
                            rd_byte <= acrb_read(instr_v[7:0]);
                            rd_idx <= 3'd0;
                        end
                    end
                    ST_DATA: begin
                        shreg <= shreg_n;
                        bit_cnt <= bit_cnt + 5'd1;
                        rd_idx <= rd_idx + 3'd1;
                        if (bit_cnt == 5'd7) begin
                            bit_cnt <= 5'd0;
                            rd_idx <= 3'd0;
                            if (!rd_mode) begin
                                case (addr)
                                    `ACRB_ADDR_SETUP: begin
                                        // R6 R7
                                        serial_port_setup <= {1'b0, wr_data[6:5], 2'b11, wr_data[2:1], 1'b0};
                                        if (wr_data[`ACRB_BIT_SRST_HI] | wr_data[`ACRB_BIT_SRST_LO])
                                            srst_cnt <= `ACRB_SRST_CYCLES;
                                    end
                                    `ACRB_ADDR_COMMIT: shadow_commit <= {7'h00, wr_data[0]}; // R10
                                    default: begin
                                        if (in_func && addr == `ACRB_ADDR_MODES)
                                            power_mode_staged <= {2'b00, wr_data[5], 2'b00, wr_data[2:0]};
                                    end
                                endcase
                            end
                            addr <= addr - 8'h01;
                            rd_byte <= acrb_read(addr - 8'h01);
                            if (bytes_left == 3'd0)
                                state <= ST_DONE;
                            else if (bytes_left != 3'd7)
                                bytes_left <= bytes_left - 3'd1;
                        end
                    end
                    default: state <= ST_DONE;
                endcase
            end else if (sclk_fall && state == ST_DATA && rd_mode) begin
                spi_sdio_oe <= 1'b1;
                spi_sdio_out <= lsb_first ? rd_byte[rd_idx] : rd_byte[3'd7 - rd_idx]; // R13
            end
        end
    end

    // Grade low bits have no reset branch but are loaded with zero on every clock
    always @(posedge ref_clk) begin
        grade_low <= 3'b000;
    end

    // --------------------------------
    // Power mode and output coding
    // --------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            power_state <= 2'd0;
            sample_output_bus <= 8'h00;
            overrange <= 1'b0;
        end else begin
            if (powerdown_pin)
                power_state <= power_mode_control[`ACRB_BIT_PIN_SEL] ? 2'd2 : 2'd1; // R12
            else begin
                case (pd_field) // R11
                    `ACRB_PD_FULL: power_state <= 2'd1;
                    `ACRB_PD_STANDBY: power_state <= 2'd2;
                    default: power_state <= 2'd0;
                endcase
            end
            // Raw sample is offset binary; flags mark excess over half LSB
            if (over_pos)
                sample_output_bus <= twos_comp_sel ? (`ACRB_OB_POS ^ `ACRB_OB_MID) : `ACRB_OB_POS; // R1 R2
            else if (over_neg)
                sample_output_bus <= twos_comp_sel ? (`ACRB_OB_NEG ^ `ACRB_OB_MID) : `ACRB_OB_NEG; // R1 R2
            else
                sample_output_bus <= twos_comp_sel ? (raw_sample ^ `ACRB_OB_MID) : raw_sample; // R2
            overrange <= over_pos | over_neg; // R1
        end
    end
endmodule // acrb_bank

// ==== bench/acrb_bank_asserts.sv ====
// Concurrent checks on the register bank ports
module acrb_bank_asserts (
    input wire ref_clk,
    input wire reset_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdio_in,
    input wire spi_sdio_out,
    input wire spi_sdio_oe,
    input wire powerdown_pin,
    input wire [7:0] raw_sample,
    input wire over_pos,
    input wire over_neg,
    input wire twos_comp_sel,
    input wire [7:0] sample_output_bus,
    input wire overrange,
    input wire [1:0] power_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_cs_idle;
        spi_cs_n [*8];
    endsequence
    sequence s_pin_held;
        powerdown_pin ##1 powerdown_pin;
    endsequence
    a_oe_idle_cs: assert property (s_cs_idle |-> !spi_sdio_oe)
        else $error("data pin driven outside a frame");
    a_oe_rise_frame: assert property ($rose(spi_sdio_oe) |-> !spi_cs_n)
        else $error("data pin enabled without chip select");
    a_obin_code: assert property ((!twos_comp_sel && !over_pos && !over_neg) |=>
        sample_output_bus == $past(raw_sample)) else $error("offset binary code wrong");
    a_twos_code: assert property ((twos_comp_sel && !over_pos && !over_neg) |=>
        sample_output_bus == ($past(raw_sample) ^ 8'h80)) else $error("twos complement code wrong");
    a_sat_pos: assert property ((over_pos && !over_neg) |=> overrange &&
        sample_output_bus == ($past(twos_comp_sel) ? 8'h7f : 8'hff)) else $error("positive saturation wrong");
    a_sat_neg: assert property ((over_neg && !over_pos) |=> overrange &&
        sample_output_bus == ($past(twos_comp_sel) ? 8'h80 : 8'h00)) else $error("negative saturation wrong");
    a_no_over: assert property ((!over_pos && !over_neg) |=> !overrange)
        else $error("overrange without cause");
    a_pin_wins: assert property (s_pin_held |-> power_state inside {2'd1, 2'd2})
        else $error("power-down pin ignored");
endmodule // acrb_bank_asserts

bind acrb_bank acrb_bank_asserts i_chk (.ref_clk(ref_clk), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .powerdown_pin(powerdown_pin), .raw_sample(raw_sample), .over_pos(over_pos), .over_neg(over_neg),
    .twos_comp_sel(twos_comp_sel), .sample_output_bus(sample_output_bus), .overrange(overrange),
    .power_state(power_state));

// ==== bench/acrb_host.sv ====
// Serial port host model for the register bank
module acrb_host (
    input wire logic ref_clk,
    input wire logic sdio_line,
    input wire logic lsb_order,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic host_sdio
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        host_sdio = 1'b0;
    end
    task automatic half;
        repeat (4) @(negedge ref_clk);
    endtask
    // Serial clock stands low outside frames; a released line shows the inverse level
    // First data byte travels in the upper half of wd and rdat
    task automatic xfer(input logic rw, input logic [7:0] addr, input int nb, input logic [15:0] wd,
        output logic [15:0] rdat);
        logic [15:0] word;
        int idx;
        word = {rw, 2'(nb - 1), 5'h00, addr};
        rdat = 16'h0000;
        spi_cs_n = 1'b0;
        for (int p = 0; p < 16 + 8 * nb; p++) begin
            if (p < 16) idx = lsb_order ? p : 15 - p;
            else idx = 8 - 8 * ((p - 16) / 8) + (lsb_order ? (p - 16) % 8 : 7 - (p - 16) % 8);
            if (p < 16) host_sdio = word[idx];
            else if (!rw) host_sdio = wd[idx];
            else if (p == 16) host_sdio = ~host_sdio;
            half();
            spi_sclk = 1'b1;
            if (rw && p >= 16) rdat[idx] = sdio_line;
            half();
            spi_sclk = 1'b0;
        end
        half();
        spi_cs_n = 1'b1;
        host_sdio = ~host_sdio;
        repeat (4) half();
    endtask
endmodule // acrb_host

// ==== bench/acrb_bank_bench.sv ====
// Self-checking bench for the converter configuration register bank
module acrb_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TB_PART_ID = 8'ha7; // Arbitrary identifier value
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic powerdown_pin = 1'b0;
    logic [7:0] raw_sample = 8'h00;
    logic over_pos = 1'b0;
    logic over_neg = 1'b0;
    logic twos_comp_sel = 1'b0;
    logic [15:0] rd;
    logic lsb_order = 1'b0;
    logic [2:0] pd_code [4] = '{3'b000, 3'b001, 3'b010, 3'b011};
    logic [1:0] pd_exp [4] = '{2'd0, 2'd1, 2'd2, 2'd0};
    wire spi_sclk, spi_cs_n, host_sdio, spi_sdio_out, spi_sdio_oe, sdio_line, overrange;
    wire [7:0] sample_output_bus;
    wire [1:0] power_state;
    int err_total = 0;
    int checks = 0;
    assign sdio_line = spi_sdio_oe ? spi_sdio_out : host_sdio;
    acrb_bank #(.PART_ID(TB_PART_ID), .SPEED_GRADE(2'b01)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdio_in(sdio_line), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .powerdown_pin(powerdown_pin), .raw_sample(raw_sample),
        .over_pos(over_pos), .over_neg(over_neg), .twos_comp_sel(twos_comp_sel),
        .sample_output_bus(sample_output_bus), .overrange(overrange), .power_state(power_state));
    acrb_host i_host (.ref_clk(ref_clk), .sdio_line(sdio_line), .lsb_order(lsb_order), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .host_sdio(host_sdio));
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        i_host.xfer(1'b1, a, 1, 16'h0000, rd);
        check8(rd[15:8], exp);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, a, 1, {d, 8'h00}, rd);
    endtask
    task automatic samp(input logic [7:0] r, input logic op, on, tc, input logic [7:0] eb, input logic eo);
        @(negedge ref_clk);
        {raw_sample, over_pos, over_neg, twos_comp_sel} = {r, op, on, tc};
        repeat (2) @(negedge ref_clk);
        check8(sample_output_bus, eb);
        check8({7'h00, overrange}, {7'h00, eo});
    endtask
    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial forever #4 ref_clk = ~ref_clk;
    initial begin
        #400us;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        reg_rd(8'h00, 8'h18);
        reg_rd(8'hff, 8'h00);
        reg_rd(8'h08, 8'h00);
        reg_rd(8'h01, TB_PART_ID);
        reg_wr(8'h01, ~TB_PART_ID);
        reg_rd(8'h01, TB_PART_ID);
        reg_rd(8'h02, 8'h08);
        reg_rd(8'h30, 8'h00);
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'h08, {5'h00, pd_code[k]});
            reg_wr(8'hff, 8'h01);
            check8({6'h00, power_state}, {6'h00, pd_exp[k]});
        end
        reg_wr(8'h08, 8'h01);
        check8({6'h00, power_state}, 8'h00);
        reg_rd(8'hff, 8'h00);
        powerdown_pin = 1'b1;
        repeat (3) @(negedge ref_clk);
        check8({6'h00, power_state}, 8'h01);
        reg_wr(8'h08, 8'h20);
        reg_wr(8'hff, 8'h01);
        check8({6'h00, power_state}, 8'h02);
        reg_rd(8'h08, 8'h20);
        powerdown_pin = 1'b0;
        repeat (3) @(negedge ref_clk);
        check8({6'h00, power_state}, 8'h00);
        samp(8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
        samp(8'h80, 1'b0, 1'b0, 1'b0, 8'h80, 1'b0);
        samp(8'hff, 1'b0, 1'b0, 1'b0, 8'hff, 1'b0);
        samp(8'hff, 1'b1, 1'b0, 1'b0, 8'hff, 1'b1);
        samp(8'h00, 1'b0, 1'b1, 1'b0, 8'h00, 1'b1);
        samp(8'h00, 1'b0, 1'b0, 1'b1, 8'h80, 1'b0);
        samp(8'h80, 1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
        samp(8'hff, 1'b0, 1'b0, 1'b1, 8'h7f, 1'b0);
        samp(8'hff, 1'b1, 1'b0, 1'b1, 8'h7f, 1'b1);
        samp(8'h00, 1'b0, 1'b1, 1'b1, 8'h80, 1'b1);
        i_host.xfer(1'b1, 8'h02, 2, 16'h0000, rd);
        check8(rd[15:8], 8'h08);
        check8(rd[7:0], TB_PART_ID);
        reg_wr(8'h00, 8'h5a);
        lsb_order = 1'b1;
        reg_rd(8'h00, 8'h5a);
        reg_rd(8'h01, TB_PART_ID);
        reg_wr(8'h00, 8'h3c);
        lsb_order = 1'b0;
        reg_rd(8'h00, 8'h18);
        reg_rd(8'h08, 8'h00);
        reg_wr(8'h08, 8'h02);
        reg_wr(8'hff, 8'h01);
        check8({6'h00, power_state}, 8'h02);
        reset_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        check8({6'h00, power_state}, 8'h00);
        reg_rd(8'h08, 8'h00);
        reg_rd(8'h00, 8'h18);
        print_verdict();
    end
endmodule // acrb_bank_bench
